// File: hdl/shutdown_pkg.sv
// Package with register map, field positions and reset values of the shutdown block
package shutdown_pkg;
    // Register indices (printed offsets are not multiples of four: byte address = 4 * index)
    localparam logic [11:0] IDX_CLOCK_SELECT = 12'hF3B;
    localparam logic [11:0] IDX_DATA_SOURCE = 12'hF3C;
    localparam logic [11:0] IDX_RISE_DB = 12'hF3D;
    localparam logic [11:0] IDX_FALL_DB = 12'hF3E;
    localparam logic [11:0] IDX_MAIN_CONTROL = 12'hF3F;
    localparam logic [11:0] IDX_POLARITY = 12'hF40;
    localparam logic [11:0] IDX_SHUTDOWN_CONTROL = 12'hF41;
    localparam logic [11:0] IDX_SOURCE_ENABLES = 12'hF42;
    localparam logic [11:0] IDX_STEERING = 12'hF43;
    // Field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_LOAD = 6;
    localparam int BIT_INPUT_VALUE = 5;
    localparam int BIT_SHUTDOWN = 7;
    localparam int BIT_RESTART = 6;
    localparam int POS_LEVEL_BD = 4;
    localparam int POS_LEVEL_AC = 2;
    // Active-low source mask: bits 0 and 4..7 active low, 1..3 active high
    localparam logic [7:0] ACTIVE_LOW_MASK = 8'hF1;
    // Reset values
    localparam logic [1:0] RST_LEVEL = 2'h1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Override level encodings
    localparam logic [1:0] LVL_INACTIVE = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h2;
    localparam logic [1:0] LVL_HIGH = 2'h3;
endpackage

// File: hdl/sync2.sv
// Two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module sync2 #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage_ff;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stage_ff <= '0;
            sync_o <= '0;
        end else begin
            stage_ff <= async_i;
            sync_o <= stage_ff;
        end
    end
endmodule

// File: hdl/waveform_auto_shutdown.sv
// Auto-shutdown and restart logic of a four-output waveform generator with Wishbone registers
`timescale 1ns/10ps
module waveform_auto_shutdown #(
    parameter int ADDR_W = 14
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic data_in_i,
    input wire logic fault_pin_select_i,
    input wire logic timer_two_postscaled_i,
    input wire logic timer_four_postscaled_i,
    input wire logic timer_six_postscaled_i,
    input wire logic comparator_one_out_i,
    input wire logic comparator_two_out_i,
    input wire logic logic_cell_two_out_i,
    input wire logic logic_cell_six_out_i,
    input wire logic sleep_i,
    output logic [3:0] wave_o,
    output logic shutdown_irq_flag_o,
    output logic internal_fast_osc_req_o
);
    // ==========================================================
    // Declarations
    logic [7:0] fault_raw;
    logic [7:0] fault_sync;
    logic data_sync;
    logic [0:0] data_sync_v;
    logic [7:0] fault_active;
    logic fault_any;
    logic clock_select_ff;
    logic [3:0] data_source_ff;
    logic [5:0] rise_db_ff;
    logic [5:0] fall_db_ff;
    logic enable_ff;
    logic load_ff;
    logic [2:0] mode_ff;
    logic [3:0] polarity_ff;
    logic shutdown_ff;
    logic restart_ff;
    logic [1:0] override_level_bd_ff;
    logic [1:0] override_level_ac_ff;
    logic [7:0] fault_source_enable_ff;
    logic [7:0] steering_ff;
    logic data_prev_ff;
    logic hold_ff;
    logic irq_ff;
    logic [3:0] wave_ff;
    logic [3:0] nxt_wave;
    logic [31:0] rd_data;
    logic ack_ff;
    logic err_ff;
    logic [31:0] dat_ff;
    logic req;
    logic mapped;
    logic [11:0] index;
    logic wr_lane0;
    logic sw_set;
    logic sw_clear;
    logic data_rise;
    logic [1:0] lvl_a;
    logic [1:0] lvl_b;
    logic sleep_sync;
    logic [0:0] sleep_sync_v;
    logic data_fall;
    logic fall_seen_ff;

    // ==========================================================
    // Input synchronisers
    assign fault_raw = {logic_cell_six_out_i, logic_cell_two_out_i, comparator_two_out_i,
                        comparator_one_out_i, timer_six_postscaled_i, timer_four_postscaled_i,
                        timer_two_postscaled_i, fault_pin_select_i};

    sync2 #(.WIDTH(8)) u_fault_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(fault_raw),
        .sync_o(fault_sync)
    );

    sync2 #(.WIDTH(1)) u_data_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(data_in_i),
        .sync_o(data_sync_v)
    );
    assign data_sync = data_sync_v[0];

    // Sleep level comes from the system clock domain
    sync2 #(.WIDTH(1)) u_sleep_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(sleep_i),
        .sync_o(sleep_sync_v)
    );
    assign sleep_sync = sleep_sync_v[0];

    // ==========================================================
    // Fault detection
    assign fault_active = (fault_sync ^ shutdown_pkg::ACTIVE_LOW_MASK) & fault_source_enable_ff;
    assign fault_any = |fault_active;
    assign data_rise = data_sync & ~data_prev_ff;
    assign data_fall = ~data_sync & data_prev_ff;

    // ==========================================================
    // Bus decode
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
    assign index = wb_adr_i[ADDR_W-1:2];
    assign wr_lane0 = req & wb_we_i & wb_sel_i[0] & mapped;
    assign sw_set = wr_lane0 && index == shutdown_pkg::IDX_SHUTDOWN_CONTROL && wb_dat_i[shutdown_pkg::BIT_SHUTDOWN];
    assign sw_clear = wr_lane0 && index == shutdown_pkg::IDX_SHUTDOWN_CONTROL
                      && !wb_dat_i[shutdown_pkg::BIT_SHUTDOWN];

    always_comb begin
        mapped = 1'b1;
        rd_data = 32'h00000000;
        case (index)
            shutdown_pkg::IDX_CLOCK_SELECT: rd_data = {31'h00000000, clock_select_ff};
            shutdown_pkg::IDX_DATA_SOURCE: rd_data = {28'h0000000, data_source_ff};
            shutdown_pkg::IDX_RISE_DB: rd_data = {26'h0000000, rise_db_ff};
            shutdown_pkg::IDX_FALL_DB: rd_data = {26'h0000000, fall_db_ff};
            shutdown_pkg::IDX_MAIN_CONTROL: rd_data = {24'h000000, enable_ff, load_ff, 3'h0, mode_ff};
            shutdown_pkg::IDX_POLARITY: rd_data = {24'h000000, 2'h0, data_sync, 1'h0, polarity_ff};
            shutdown_pkg::IDX_SHUTDOWN_CONTROL: rd_data = {24'h000000, shutdown_ff, restart_ff,
                                                   override_level_bd_ff, override_level_ac_ff, 2'h0};
            shutdown_pkg::IDX_SOURCE_ENABLES: rd_data = {24'h000000, fault_source_enable_ff};
            shutdown_pkg::IDX_STEERING: rd_data = {24'h000000, steering_ff};
            default: mapped = 1'b0;
        endcase
    end

    // ==========================================================
    // Bus answer: one cycle after request, error for unmapped
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else begin
            ack_ff <= req & mapped;
            err_ff <= req & ~mapped;
            dat_ff <= (req & mapped & ~wb_we_i) ? rd_data : 32'h00000000;
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            clock_select_ff <= 1'b0;
            data_source_ff <= 4'h0;
            rise_db_ff <= 6'h00;
            fall_db_ff <= 6'h00;
            enable_ff <= 1'b0;
            mode_ff <= 3'h0;
            polarity_ff <= 4'h0;
            restart_ff <= 1'b0;
            override_level_bd_ff <= shutdown_pkg::RST_LEVEL;
            override_level_ac_ff <= shutdown_pkg::RST_LEVEL;
            fault_source_enable_ff <= shutdown_pkg::RST_BYTE;
            steering_ff <= shutdown_pkg::RST_BYTE;
        end else if (wr_lane0) begin
            case (index)
                shutdown_pkg::IDX_CLOCK_SELECT: clock_select_ff <= wb_dat_i[0];
                shutdown_pkg::IDX_DATA_SOURCE: data_source_ff <= wb_dat_i[3:0];
                shutdown_pkg::IDX_RISE_DB: rise_db_ff <= wb_dat_i[5:0];
                shutdown_pkg::IDX_FALL_DB: fall_db_ff <= wb_dat_i[5:0];
                shutdown_pkg::IDX_MAIN_CONTROL: begin
                    enable_ff <= wb_dat_i[shutdown_pkg::BIT_ENABLE];
                    mode_ff <= wb_dat_i[2:0];
                end
                shutdown_pkg::IDX_POLARITY: polarity_ff <= wb_dat_i[3:0];
                shutdown_pkg::IDX_SHUTDOWN_CONTROL: begin
                    restart_ff <= wb_dat_i[shutdown_pkg::BIT_RESTART];
                    override_level_bd_ff <= wb_dat_i[shutdown_pkg::POS_LEVEL_BD +: 2];
                    override_level_ac_ff <= wb_dat_i[shutdown_pkg::POS_LEVEL_AC +: 2];
                end
                shutdown_pkg::IDX_SOURCE_ENABLES: fault_source_enable_ff <= wb_dat_i[7:0];
                shutdown_pkg::IDX_STEERING: steering_ff <= wb_dat_i[7:0];
                default: clock_select_ff <= clock_select_ff;
            endcase
        end
    end

    // ==========================================================
    // Load bit: set only while enabled, cleared by hardware
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            load_ff <= 1'b0;
        end else if (wr_lane0 && index == shutdown_pkg::IDX_MAIN_CONTROL && enable_ff
                     && wb_dat_i[shutdown_pkg::BIT_LOAD]) begin
            load_ff <= 1'b1;
        end else if (!enable_ff || (data_rise && fall_seen_ff)) begin
            load_ff <= 1'b0;
        end
    end

    // Load waits for a data fall, then clears on the following rise
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fall_seen_ff <= 1'b0;
        end else if (!load_ff) begin
            fall_seen_ff <= 1'b0;
        end else if (data_fall) begin
            fall_seen_ff <= 1'b1;
        end
    end

    // ==========================================================
    // Shutdown status bit
    // Set by software or fault wins over any clear in the same cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            shutdown_ff <= 1'b0;
        end else if (sw_set || fault_any) begin
            shutdown_ff <= 1'b1;
        end else if (sw_clear) begin
            shutdown_ff <= 1'b0;
        end else if (restart_ff) begin
            shutdown_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Output hold until the first data rise after shutdown clears; starts held
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hold_ff <= 1'b1;
        end else if (shutdown_ff || fault_any || !enable_ff) begin
            hold_ff <= 1'b1;
        end else if (data_rise) begin
            hold_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            data_prev_ff <= 1'b0;
        end else begin
            data_prev_ff <= data_sync;
        end
    end

    // ==========================================================
    // Interrupt flag pulse when shutdown is set by software or fault while the status bit is clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (sw_set || fault_any) && !shutdown_ff;
        end
    end

    // ==========================================================
    // Output path
    // Codes 00 and 01 give the inactive low level
    function automatic logic level_out(input logic [1:0] lvl, input logic keep);
        case (lvl)
            shutdown_pkg::LVL_LOW: level_out = 1'b0;
            shutdown_pkg::LVL_HIGH: level_out = 1'b1;
            default: level_out = keep;
        endcase
    endfunction

    assign lvl_a = override_level_ac_ff;
    assign lvl_b = override_level_bd_ff;

    always_comb begin
        nxt_wave = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (steering_ff[i]) begin
                nxt_wave[i] = data_sync ^ polarity_ff[i];
            end else begin
                nxt_wave[i] = steering_ff[i+4];
            end
        end
        if (hold_ff || shutdown_ff || fault_any || sw_set) begin
            // Override levels bypass polarity
            nxt_wave[0] = level_out(lvl_a, 1'b0);
            nxt_wave[2] = level_out(lvl_a, 1'b0);
            nxt_wave[1] = level_out(lvl_b, 1'b0);
            nxt_wave[3] = level_out(lvl_b, 1'b0);
        end
        if (!enable_ff) begin
            nxt_wave = 4'h0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wave_ff <= 4'h0;
        end else begin
            wave_ff <= nxt_wave;
        end
    end

    // ==========================================================
    // Oscillator request kept in sleep when enabled, input active, selected
    // In sleep the request also follows the data input
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            internal_fast_osc_req_o <= 1'b0;
        end else begin
            internal_fast_osc_req_o <= enable_ff && clock_select_ff && (data_sync || !sleep_sync);
        end
    end

    assign wave_o = wave_ff;
    assign shutdown_irq_flag_o = irq_ff;
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = dat_ff;
endmodule

// File: dv/shutdown_props.sv
// Port-level property checker for the auto-shutdown block
`timescale 1ns/10ps
module shutdown_props #(
    parameter int ADDR_W = 14
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic sleep_i,
    input wire logic [3:0] wave_o,
    input wire logic shutdown_irq_flag_o,
    input wire logic internal_fast_osc_req_o
);
    // ==========
    // Shadow copies of written registers
    logic [7:0] sd_ff;
    logic run_ff, cs_ff, hold_ff, wr_hit, sd_wr;
    logic [11:0] idx;
    logic [3:0] ovr;
    assign idx = wb_adr_i[ADDR_W-1:2];
    assign wr_hit = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign sd_wr = wr_hit && idx == shutdown_pkg::IDX_SHUTDOWN_CONTROL;
    assign ovr = {sd_ff[5:4] == 2'h3, sd_ff[3:2] == 2'h3, sd_ff[5:4] == 2'h3, sd_ff[3:2] == 2'h3};
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sd_ff <= 8'h14;
            run_ff <= 1'h0;
            cs_ff <= 1'h0;
            hold_ff <= 1'h0;
        end else if (wr_hit) begin
            if (sd_wr) begin
                sd_ff <= wb_dat_i[7:0];
                hold_ff <= wb_dat_i[7] && !wb_dat_i[6];
            end
            if (idx == shutdown_pkg::IDX_MAIN_CONTROL) run_ff <= wb_dat_i[7];
            if (idx == shutdown_pkg::IDX_CLOCK_SELECT) cs_ff <= wb_dat_i[0];
        end
    end
    // ==========
    // Properties
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    chk_sw_shutdown: assert property (sd_wr && wb_dat_i[7] && run_ff |=> wave_o == ovr)
        else $error("software shutdown not applied");
    chk_sw_hold: assert property (hold_ff && run_ff && !wb_ack_o |-> wave_o == ovr)
        else $error("shutdown hold lost");
    chk_irq_on_write: assert property (sd_wr && wb_dat_i[7] && !sd_ff[7] |-> ##[0:2] shutdown_irq_flag_o)
        else $error("no flag on software shutdown");
    chk_irq_pulse: assert property (shutdown_irq_flag_o |=> !shutdown_irq_flag_o)
        else $error("flag longer than one cycle");
    chk_osc_request: assert property ((!sleep_i && !wb_ack_o) [*4] |->
        internal_fast_osc_req_o == (run_ff && cs_ff)) else $error("oscillator request wrong");
    chk_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered");
    chk_answer_pulse: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
        else $error("answer longer than one cycle");
    chk_read_lane: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read lanes not zero");
endmodule

// File: dv/fault_source_model.sv
// Behavioural model of the eight fault sources seen by the shutdown block
`timescale 1ns/10ps
module fault_source_model (
    input wire logic [7:0] active_i,
    output logic [7:0] lines_o
);
    // ==========
    // Active-low sources idle high, timer sources idle low
    assign lines_o = active_i ^ shutdown_pkg::ACTIVE_LOW_MASK;
endmodule

// File: dv/waveform_auto_shutdown_tb.sv
// Testbench for registers, fault sources and data input of the shutdown block
`timescale 1ns/10ps
module waveform_auto_shutdown_tb;
    logic clock_i, rst_i, cyc, stb, we, data, sleep, ack, err, irq, osc, err_seen;
    logic [13:0] adr;
    logic [3:0] sel, wave, pol;
    logic [31:0] wd, rdat;
    logic [7:0] act, lines, sc, str, rd, v;
    int miscompares, num_checks, irq_n, n0, seed;
    waveform_auto_shutdown i_dut (.clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .data_in_i(data), .fault_pin_select_i(lines[0]), .timer_two_postscaled_i(lines[1]),
        .timer_four_postscaled_i(lines[2]), .timer_six_postscaled_i(lines[3]), .comparator_one_out_i(lines[4]),
        .comparator_two_out_i(lines[5]), .logic_cell_two_out_i(lines[6]), .logic_cell_six_out_i(lines[7]),
        .sleep_i(sleep), .wave_o(wave), .shutdown_irq_flag_o(irq), .internal_fast_osc_req_o(osc));
    fault_source_model i_src (.active_i(act), .lines_o(lines));
    initial begin
        clock_i = 1'h0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i) if (irq === 1'h1) irq_n++;
    // ==========
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] v);
        @(posedge clock_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {i, 2'h0};
        wd <= {24'h0, v};
        sel <= 4'hF;
        do begin
            @(posedge clock_i);
        end while (ack !== 1'h1 && err !== 1'h1);
        rd = rdat[7:0];
        err_seen = err;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] i, input logic [7:0] v);
        bus(1'h1, i, v);
    endtask
    task automatic rdc(input logic [11:0] i, input logic [7:0] e);
        bus(1'h0, i, 8'h00);
        chk(rd, e);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic rise;
        data <= 1'h0;
        waitc(4);
        data <= 1'h1;
        waitc(5);
    endtask
    function automatic logic [3:0] ovr_f(input logic [7:0] s);
        return {s[5:4] == 2'h3, s[3:2] == 2'h3, s[5:4] == 2'h3, s[3:2] == 2'h3};
    endfunction
    function automatic logic [3:0] run_f(input logic d);
        logic [3:0] r;
        for (int k = 0; k < 4; k++) r[k] = str[k] ? d ^ pol[k] : str[k + 4];
        return r;
    endfunction
    task automatic close_out;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        miscompares++;
        close_out;
    end
    // ==========
    // Scenarios
    initial begin
        {cyc, stb, we, data, sleep, err_seen, adr, sel, wd, act} = '0;
        rst_i = 1'h1;
        seed = $urandom(32'hE87AFD1E);
        repeat (6) @(posedge clock_i);
        rst_i <= 1'h0;
        rdc(shutdown_pkg::IDX_SHUTDOWN_CONTROL, 8'h14);
        bus(1'h0, 12'hF44, 8'h00);
        chk(err_seen, 1'h1);
        str = 8'($urandom);
        pol = 4'($urandom);
        sc = 8'($urandom) & 8'h3C;
        wr(shutdown_pkg::IDX_MAIN_CONTROL, 8'h00);
        v = 8'($urandom);
        wr(shutdown_pkg::IDX_MAIN_CONTROL, v & 8'h07);
        wr(shutdown_pkg::IDX_DATA_SOURCE, v);
        wr(shutdown_pkg::IDX_RISE_DB, v);
        wr(shutdown_pkg::IDX_FALL_DB, ~v);
        rdc(shutdown_pkg::IDX_MAIN_CONTROL, v & 8'h07);
        rdc(shutdown_pkg::IDX_DATA_SOURCE, v & 8'h0F);
        rdc(shutdown_pkg::IDX_RISE_DB, v & 8'h3F);
        rdc(shutdown_pkg::IDX_FALL_DB, ~v & 8'h3F);
        wr(shutdown_pkg::IDX_POLARITY, {4'h0, pol});
        wr(shutdown_pkg::IDX_STEERING, str);
        wr(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc);
        wr(shutdown_pkg::IDX_CLOCK_SELECT, 8'h01);
        wr(shutdown_pkg::IDX_MAIN_CONTROL, 8'h80);
        waitc(3);
        chk(wave, ovr_f(sc));
        rise;
        chk(wave, run_f(1'h1));
        sc = 8'($urandom) & 8'h3C;
        n0 = irq_n;
        wr(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc | 8'h80);
        waitc(3);
        chk(wave, ovr_f(sc));
        chk(irq_n - n0, 1);
        rise;
        rdc(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc | 8'h80);
        chk(wave, ovr_f(sc));
        wr(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc);
        rise;
        chk(wave, run_f(1'h1));
        for (int i = 0; i < 8; i++) begin
            sc = 8'($urandom) & 8'h3C;
            pol = 4'($urandom);
            wr(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc);
            wr(shutdown_pkg::IDX_POLARITY, {4'h0, pol});
            wr(shutdown_pkg::IDX_SOURCE_ENABLES, 8'h01 << i);
            n0 = irq_n;
            act <= 8'h01 << i;
            waitc(6);
            chk(wave, ovr_f(sc));
            chk(irq_n - n0, 1);
            wr(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc);
            rise;
            rdc(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc | 8'h80);
            chk(wave, ovr_f(sc));
            if (i % 2 == 1) wr(shutdown_pkg::IDX_SOURCE_ENABLES, 8'h00);
            else act <= 8'h00;
            waitc(4);
            wr(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc);
            rise;
            chk(wave, run_f(1'h1));
        end
        act <= 8'h00;
        sc = (8'($urandom) & 8'h3C) | 8'h40;
        wr(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc);
        wr(shutdown_pkg::IDX_SOURCE_ENABLES, 8'h02);
        act <= 8'h02;
        waitc(6);
        chk(wave, ovr_f(sc));
        act <= 8'h00;
        data <= 1'h0;
        waitc(6);
        rdc(shutdown_pkg::IDX_SHUTDOWN_CONTROL, sc);
        chk(wave, ovr_f(sc));
        rise;
        chk(wave, run_f(1'h1));
        sleep <= 1'h1;
        data <= 1'h0;
        waitc(5);
        chk(osc, 1'h0);
        data <= 1'h1;
        waitc(5);
        chk(osc, 1'h1);
        chk(wave, run_f(1'h1));
        close_out;
    end
endmodule
bind waveform_auto_shutdown shutdown_props #(.ADDR_W(ADDR_W)) i_props (.clock_i(clock_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_i(sleep_i),
    .wave_o(wave_o), .shutdown_irq_flag_o(shutdown_irq_flag_o), .internal_fast_osc_req_o(internal_fast_osc_req_o));
